// [src/rshs_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rshs_cfg.svh"
module rshs_top
  import rshs_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic cts_i,
  input wire logic dsr_i,
  input wire logic dcd_i,
  input wire logic ri_i,
  output logic rts_o,
  output logic dtr_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_eof_i
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  rshs_mode_t mode_q, mode_d;
  rshs_tx_t st_q, st_d;
  logic [7:0] flim_q, flim_d;
  logic set_dtr_q, set_dtr_d, set_rts_q, set_rts_d;
  logic [23:0] time_q, time_d;
  logic rts_q, rts_d, dtr_q, dtr_d;
  logic [8:0] hold_q, hold_d;
  logic hold_v_q, hold_v_d;
  logic txv_q, txv_d, txfc_q, txfc_d, last_q, last_d;
  logic [7:0] txd_q, txd_d;
  logic xoff_q, xoff_d, thr_q, thr_d, fcp_q, fcp_d;
  logic [7:0] fcc_q, fcc_d;
  logic [9:0] wp_q, wp_d, rp_q, rp_d, fs_q, fs_d;
  logic [10:0] cnt_q, cnt_d, flen_q, flen_d, disc;
  logic [7:0] frames_q, frames_d;
  logic drop_q, drop_d, dsr_p_q;
  logic [15:0] err_q, err_d;
  logic [7:0] diag_q, diag_d;
  logic [31:0] rdata_q, rdata_d;
  logic [8:0] mem [0:1023];
  logic [3:0] sig;
  logic cts, dsr;
  logic flow, susp, sent, pop, hi, acc, inc, mem_we, wr_ctrl, dfree, ab;
  logic [15:0] ab_code;

  rshs_tmr_if tmr ();

  // Pin synchronisers
  rshs_sync #(.W(4)) u_sync (
    .clk_i(ref_clk_i),
    .reset_i(reset_i),
    .ce_i(clk_en_i),
    .async_i({ri_i, dcd_i, dsr_i, cts_i}),
    .sync_o(sig)
  );

  // Shared interval timer
  rshs_timer u_tmr (
    .clk_i(ref_clk_i),
    .reset_i(reset_i),
    .ce_i(clk_en_i),
    .t(tmr.tmr)
  );

  assign cts = sig[0];
  assign dsr = sig[1];

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    mode_d = mode_q;
    st_d = st_q;
    flim_d = flim_q;
    set_dtr_d = set_dtr_q;
    set_rts_d = set_rts_q;
    time_d = time_q;
    rts_d = rts_q;
    dtr_d = dtr_q;
    hold_d = hold_q;
    hold_v_d = hold_v_q;
    txv_d = txv_q;
    txd_d = txd_q;
    txfc_d = txfc_q;
    last_d = last_q;
    xoff_d = xoff_q;
    thr_d = thr_q;
    fcp_d = fcp_q;
    fcc_d = fcc_q;
    wp_d = wp_q;
    rp_d = rp_q;
    fs_d = fs_q;
    flen_d = flen_q;
    frames_d = frames_q;
    drop_d = drop_q;
    err_d = err_q;
    diag_d = diag_q;
    disc = 11'h000;
    inc = 1'b0;
    mem_we = 1'b0;
    ab = 1'b0;
    ab_code = 16'h0000;
    tmr.load = 1'b0;
    tmr.value = 8'h00;
    flow = (mode_q == M_HW) || (mode_q == M_SW);
    susp = ((mode_q == M_SW) && xoff_q) || ((mode_q == M_HW) && !cts); // RQ15
    sent = txv_q && tx_ready_i;
    dfree = (!txv_q || sent) && !((mode_q == M_SW) && fcp_q);
    wr_ctrl = reg_wr_i && (reg_addr_i == `RSHS_A_CTRL);
    pop = reg_rd_i && (reg_addr_i == `RSHS_A_RXD) && (cnt_q != 11'h000);
    hi = (cnt_q >= (`RSHS_RX_DEPTH - `RSHS_RX_MARGIN)) || ((flim_q != 8'h00) && (frames_q >= flim_q));
    acc = (mode_q != M_AUTO) || (dsr && dtr_q); // RQ2 RQ6
    // Clears first, so that a new event in the same cycle wins
    if (reg_rd_i && (reg_addr_i == `RSHS_A_STAT)) begin
      err_d = 16'h0000;
    end
    if (reg_wr_i && (reg_addr_i == `RSHS_A_DIAG)) begin
      diag_d = 8'h00;
    end
    // Host writes
    if (wr_ctrl) begin
      mode_d = rshs_mode_t'(reg_wdata_i[`RSHS_F_MODE +: 2]);
      flim_d = reg_wdata_i[`RSHS_F_FLIM +: 8];
      st_d = TX_IDLE;
      hold_v_d = 1'b0;
      thr_d = 1'b0;
      xoff_d = 1'b0;
      if (mode_d != mode_q) begin
        unique case (mode_d)
          M_AUTO: begin
            rts_d = 1'b0; // RQ1
            dtr_d = 1'b1; // RQ1
          end
          M_HW: rts_d = 1'b1; // RQ11
          M_SW: begin
            fcp_d = 1'b1; // RQ11
            fcc_d = `RSHS_XON;
          end
          M_NONE: rts_d = set_rts_q;
        endcase
      end
    end
    if (reg_wr_i && (reg_addr_i == `RSHS_A_SET) && (mode_q != M_AUTO)) begin // RQ8
      set_dtr_d = reg_wdata_i[`RSHS_F_DTR]; // RQ17
      if (mode_q != M_HW) begin // RQ9
        set_rts_d = reg_wdata_i[`RSHS_F_RTS];
      end
    end
    if (reg_wr_i && (reg_addr_i == `RSHS_A_TIME)) begin
      time_d = reg_wdata_i[23:0];
    end
    if (reg_wr_i && (reg_addr_i == `RSHS_A_TXD) && !hold_v_q) begin
      hold_d = reg_wdata_i[8:0];
      hold_v_d = 1'b1;
    end
    // Host-driven outputs outside the automatic mode
    if (!wr_ctrl && (mode_q != M_AUTO)) begin
      dtr_d = set_dtr_d;
      if (mode_q != M_HW) begin
        rts_d = set_rts_d;
      end
    end
    // Transmit hand-off to the line
    if (sent) begin
      txv_d = 1'b0;
    end
    if ((!txv_q || sent) && fcp_q && (mode_q == M_SW)) begin
      txv_d = 1'b1;
      txd_d = fcc_q;
      txfc_d = 1'b1;
      fcp_d = 1'b0;
    end
    // Send sequencer
    if (!wr_ctrl) begin
      unique case (st_q)
        TX_IDLE: begin
          if (hold_v_q) begin
            if (mode_q != M_AUTO) begin
              st_d = TX_ACT;
            end else if (!dtr_q) begin
              ab = 1'b1; // RQ2
              ab_code = `RSHS_E_DTR;
            end else begin
              rts_d = 1'b1; // RQ3
              tmr.load = 1'b1;
              tmr.value = time_q[`RSHS_F_OW +: 8];
              st_d = TX_WAIT;
            end
          end
        end
        TX_WAIT: begin
          if (tmr.done) begin
            if (cts) begin
              st_d = TX_ACT; // RQ3
            end else begin
              ab = 1'b1; // RQ4
              ab_code = `RSHS_E_CTS;
            end
          end
        end
        TX_ACT: begin
          if ((mode_q == M_AUTO) && !cts) begin
            ab = 1'b1; // RQ4
            ab_code = `RSHS_E_CTS;
            txv_d = 1'b0;
          end else if (sent && !txfc_q && last_q) begin
            if (mode_q == M_AUTO) begin
              tmr.load = 1'b1; // RQ5
              tmr.value = time_q[`RSHS_F_ROFF +: 8];
              st_d = TX_OFF;
            end else begin
              st_d = TX_IDLE;
            end
          end else if (hold_v_q && susp) begin
            tmr.load = 1'b1; // RQ15
            tmr.value = time_q[`RSHS_F_FTO +: 8];
            st_d = TX_SUSP;
          end else if (hold_v_q && dfree) begin
            txv_d = 1'b1;
            txd_d = hold_q[7:0];
            txfc_d = 1'b0;
            last_d = hold_q[`RSHS_F_LAST];
            hold_v_d = 1'b0;
          end
        end
        TX_SUSP: begin
          if (!susp) begin
            st_d = TX_ACT;
          end else if (tmr.done) begin
            ab = 1'b1; // RQ16
            ab_code = `RSHS_E_FLOW;
          end
        end
        TX_OFF: begin
          if (tmr.done) begin
            rts_d = 1'b0; // RQ5
            st_d = TX_IDLE;
          end
        end
        default: st_d = TX_IDLE;
      endcase
    end
    if (ab) begin
      st_d = TX_IDLE;
      hold_v_d = 1'b0;
      err_d = ab_code;
      if (mode_q == M_AUTO) begin
        rts_d = 1'b0;
      end
    end
    // Flow control toward the partner, only in the hardware and software flow modes
    if (flow && !wr_ctrl) begin
      if (hi && !thr_q) begin
        thr_d = 1'b1; // RQ12
        if (mode_q == M_SW) begin
          fcp_d = 1'b1;
          fcc_d = `RSHS_XOFF;
        end
      end else if (!hi && thr_q) begin
        thr_d = 1'b0; // RQ14
        if (mode_q == M_SW) begin
          fcp_d = 1'b1;
          fcc_d = `RSHS_XON;
        end
      end
      if (mode_q == M_HW) begin
        rts_d = !thr_d;
      end
    end
    // Receive ring: oldest entry leaves first
    if (pop) begin
      rp_d = rp_q + 10'h001; // RQ19
      if (mem[rp_q][8]) begin
        frames_d = frames_q - 8'h01;
      end
    end
    if (rx_valid_i) begin
      if ((mode_q == M_SW) && (rx_data_i == `RSHS_XOFF)) begin
        xoff_d = 1'b1; // RQ15
      end else if ((mode_q == M_SW) && (rx_data_i == `RSHS_XON)) begin
        xoff_d = 1'b0;
      end else if (acc) begin
        if (drop_q) begin
          drop_d = !rx_eof_i;
        end else if (cnt_q == `RSHS_RX_DEPTH) begin
          err_d = `RSHS_E_OVF; // RQ13
          wp_d = fs_q;
          disc = flen_q;
          flen_d = 11'h000;
          drop_d = !rx_eof_i;
        end else begin
          mem_we = 1'b1;
          inc = 1'b1;
          wp_d = wp_q + 10'h001;
          if (rx_eof_i) begin
            frames_d = frames_d + 8'h01;
            fs_d = wp_q + 10'h001;
            flen_d = 11'h000;
          end else begin
            flen_d = flen_q + 11'h001;
          end
        end
      end
    end
    // Partner-ready fall in automatic mode
    if ((mode_q == M_AUTO) && dsr_p_q && !dsr) begin
      err_d = `RSHS_E_DSR; // RQ7
      diag_d = `RSHS_D_DSR; // RQ7
      st_d = TX_IDLE;
      hold_v_d = 1'b0;
      rts_d = 1'b0;
      wp_d = fs_q;
      disc = flen_q;
      flen_d = 11'h000;
      drop_d = 1'b0;
    end
    cnt_d = cnt_q + {10'h000, inc} - {10'h000, pop} - disc;
  end

  // Read port, data in the cycle after the strobe
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd_i) begin
      if (reg_addr_i == `RSHS_A_CTRL) rdata_d = {22'h000000, flim_q, mode_q};
      if (reg_addr_i == `RSHS_A_SET) rdata_d = {30'h00000000, set_rts_q, set_dtr_q};
      if (reg_addr_i == `RSHS_A_STAT) rdata_d = {err_q, 6'h00, st_q != TX_IDLE, hold_v_q, 2'h0, sig, dtr_q, rts_q}; // RQ10 RQ17
      if (reg_addr_i == `RSHS_A_RXD) rdata_d = {22'h000000, cnt_q != 11'h000, mem[rp_q]};
      if (reg_addr_i == `RSHS_A_TIME) rdata_d = {8'h00, time_q};
      if (reg_addr_i == `RSHS_A_DIAG) rdata_d = {24'h000000, diag_q};
    end
  end

  // Receive storage
  always_ff @(posedge ref_clk_i) begin
    if (clk_en_i && mem_we) begin
      mem[wp_q] <= {rx_eof_i, rx_data_i};
    end
  end

  // State registers; outputs start inactive
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_q <= M_NONE;
      st_q <= TX_IDLE;
      flim_q <= `RSHS_R_FLIM;
      set_dtr_q <= 1'b0;
      set_rts_q <= 1'b0;
      time_q <= `RSHS_R_TIME;
      rts_q <= 1'b0; // RQ18
      dtr_q <= 1'b0; // RQ18
      hold_q <= 9'h000;
      hold_v_q <= 1'b0;
      txv_q <= 1'b0;
      txd_q <= 8'h00;
      txfc_q <= 1'b0;
      last_q <= 1'b0;
      xoff_q <= 1'b0;
      thr_q <= 1'b0;
      fcp_q <= 1'b0;
      fcc_q <= 8'h00;
      wp_q <= 10'h000;
      rp_q <= 10'h000;
      fs_q <= 10'h000;
      cnt_q <= 11'h000;
      flen_q <= 11'h000;
      frames_q <= 8'h00;
      drop_q <= 1'b0;
      dsr_p_q <= 1'b0;
      err_q <= 16'h0000;
      diag_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else if (clk_en_i) begin
      mode_q <= mode_d;
      st_q <= st_d;
      flim_q <= flim_d;
      set_dtr_q <= set_dtr_d;
      set_rts_q <= set_rts_d;
      time_q <= time_d;
      rts_q <= rts_d;
      dtr_q <= dtr_d;
      hold_q <= hold_d;
      hold_v_q <= hold_v_d;
      txv_q <= txv_d;
      txd_q <= txd_d;
      txfc_q <= txfc_d;
      last_q <= last_d;
      xoff_q <= xoff_d;
      thr_q <= thr_d;
      fcp_q <= fcp_d;
      fcc_q <= fcc_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      fs_q <= fs_d;
      cnt_q <= cnt_d;
      flen_q <= flen_d;
      frames_q <= frames_d;
      drop_q <= drop_d;
      dsr_p_q <= dsr;
      err_q <= err_d;
      diag_q <= diag_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign rts_o = rts_q;
  assign dtr_o = dtr_q;
  assign tx_valid_o = txv_q;
  assign tx_data_o = txd_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i || !clk_en_i);

  sequence s_wait_end;
    (st_q == TX_WAIT) && tmr.done;
  endsequence

  a_auto_entry: assert property (wr_ctrl && (reg_wdata_i[1:0] == 2'b01) && (mode_q != M_AUTO) |=> !rts_q && dtr_q) // RQ1
    else $error("auto entry outputs wrong");
  a_dtr_reject: assert property ((mode_q == M_AUTO) && !(dtr_q && dsr) && !dsr_p_q && rx_valid_i // RQ2 RQ6
    |=> $stable(wp_q))
    else $error("byte taken with terminal-ready off");
  a_wait_start: assert property (s_wait_end ##0 cts && !wr_ctrl && dsr_p_q == dsr |=> st_q == TX_ACT) // RQ3
    else $error("send not started after wait");
  a_cts_abort: assert property (s_wait_end ##0 !cts && !wr_ctrl |=> (st_q == TX_IDLE) && !rts_q) // RQ4
    else $error("missing clear-to-send abort");
  a_rts_off: assert property ((st_q == TX_OFF) && tmr.done && !wr_ctrl |=> !rts_q ##1 !rts_q || wr_ctrl) // RQ5
    else $error("request-to-send not released");
  a_dsr_diag: assert property ((mode_q == M_AUTO) && dsr_p_q && !dsr |=> diag_q == `RSHS_D_DSR) // RQ7
    else $error("partner-ready fall not recorded");
  a_set_block: assert property ((mode_q == M_AUTO) && reg_wr_i && (reg_addr_i == `RSHS_A_SET) |=> $stable(set_rts_q)) // RQ8
    else $error("host set accepted in auto mode");
  a_hw_rts: assert property ((mode_q == M_HW) && $past(mode_q) == M_HW && !$past(wr_ctrl) |-> rts_q == !thr_q) // RQ9
    else $error("hardware flow output mismatch");
  a_flow_abort: assert property ((st_q == TX_SUSP) && susp && tmr.done && !wr_ctrl |=> err_q == `RSHS_E_FLOW) // RQ16
    else $error("suspend timeout code missing");
endmodule
`default_nettype wire

// [src/rshs_cfg.svh]
`ifndef RSHS_CFG_SVH
`define RSHS_CFG_SVH
// Overview of operation
// RQ1: Auto mode entry: RTS off, DTR on
// RQ2: Auto, DTR off: reject receive, abort sends
// RQ3: Send: RTS on, wait timer, then CTS
// RQ4: No CTS in time or CTS drop aborts
// RQ5: After last byte wait, then RTS off
// RQ6: Auto receive only with DSR; no throttling
// RQ7: DSR fall aborts, records diagnostic cause
// RQ8: Auto mode blocks flow control, host set
// RQ9: Hardware flow mode blocks host RTS set
// RQ10: Host reads every secondary signal always
// RQ11: Flow mode entry: send XON or RTS on
// RQ12: Frame limit or near full: throttle partner
// RQ13: Overflow: error, discard frame in progress
// RQ14: Frame fetched and room: release partner
// RQ15: XOFF or CTS off suspends transmission
// RQ16: Suspend timeout aborts with code 0708
// RQ17: Host status read and output set functions
// RQ18: Outputs inactive after power-up
// RQ19: Receive ring hands oldest frame first
// RQ20: Intervals are counters on a time base

// ----------------------------------------
// Register offsets (word index)
// ----------------------------------------
`define RSHS_A_CTRL 3'h0
`define RSHS_A_SET 3'h1
`define RSHS_A_STAT 3'h2
`define RSHS_A_TXD 3'h3
`define RSHS_A_RXD 3'h4
`define RSHS_A_TIME 3'h5
`define RSHS_A_DIAG 3'h6

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RSHS_F_MODE 0
`define RSHS_F_FLIM 2
`define RSHS_F_DTR 0
`define RSHS_F_RTS 1
`define RSHS_F_LAST 8
`define RSHS_F_OW 0
`define RSHS_F_ROFF 8
`define RSHS_F_FTO 16

// ----------------------------------------
// Reset values, codes and timing
// ----------------------------------------
`define RSHS_R_TIME 24'h0a0a0a
`define RSHS_R_FLIM 8'h00
`define RSHS_XON 8'h11
`define RSHS_XOFF 8'h13
`define RSHS_E_FLOW 16'h0708
`define RSHS_E_CTS 16'h0701
`define RSHS_E_DTR 16'h0702
`define RSHS_E_DSR 16'h0703
`define RSHS_E_OVF 16'h0704
`define RSHS_D_DSR 8'h01
`define RSHS_RX_DEPTH 11'h400
`define RSHS_RX_MARGIN 11'h032
`define RSHS_CLK_NS 50
`define RSHS_TICK_NS 1000
`define RSHS_TICK_CYC (`RSHS_TICK_NS / `RSHS_CLK_NS)
`endif

// [src/rshs_pkg.sv]
package rshs_pkg;
  typedef enum logic [1:0] {M_NONE = 2'b00, M_AUTO = 2'b01, M_HW = 2'b10, M_SW = 2'b11} rshs_mode_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_WAIT = 3'b001, TX_ACT = 3'b010, TX_OFF = 3'b011, TX_SUSP = 3'b100
  } rshs_tx_t;
endpackage

// [src/rshs_tmr_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface rshs_tmr_if;
  logic load;
  logic [7:0] value;
  logic done;
  modport ctl (output load, output value, input done);
  modport tmr (input load, input value, output done);
endinterface
`default_nettype wire

// [src/rshs_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rshs_cfg.svh"
module rshs_timer (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  rshs_tmr_if.tmr t
);
  logic [4:0] pre_q, pre_d;
  logic [7:0] cnt_q, cnt_d;

  // Load, then count ticks down to zero
  always_comb begin
    pre_d = pre_q;
    cnt_d = cnt_q;
    if (t.load) begin
      pre_d = 5'h00;
      cnt_d = t.value;
    end else if (cnt_q != 8'h00) begin
      if (pre_q == 5'(`RSHS_TICK_CYC - 1)) begin
        pre_d = 5'h00;
        cnt_d = cnt_q - 8'h01; // RQ20
      end else begin
        pre_d = pre_q + 5'h01;
      end
    end
  end

  // State registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pre_q <= 5'h00;
      cnt_q <= 8'h00;
    end else if (ce_i) begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
    end
  end

  assign t.done = (cnt_q == 8'h00);
endmodule
`default_nettype wire

// [src/rshs_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module rshs_sync #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q, out_d;

  // A bit changes only where the last two stages agree
  always_comb begin
    out_d = (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & out_q);
  end

  // Three-stage chain
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else if (ce_i) begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_o = out_q;
endmodule
`default_nettype wire

// [testbench/rshs_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module rshs_partner (
  input wire logic clk_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o,
  output logic cts_o,
  output logic dsr_o,
  output logic dcd_o,
  output logic ri_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_eof_o
);
  logic [7:0] taken[$];
  logic stall = 1'b0;
  logic pend = 1'b0;
  logic pend_eof = 1'b0;
  logic [7:0] pend_b = 8'h00;

  // Quiet pins at time zero
  initial begin
    {cts_o, dsr_o, dcd_o, ri_o} = 4'h0;
    {tx_ready_o, rx_valid_o, rx_eof_o} = 3'h0;
    rx_data_o = 8'h5a;
  end

  // Line receiver; a stall models a slow partner
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      taken.push_back(tx_data_i);
    end
    tx_ready_o <= !stall;
  end

  // Byte launcher; idle data flips so stale bytes never look valid
  always @(posedge clk_i) begin
    rx_valid_o <= pend;
    rx_eof_o <= pend && pend_eof;
    rx_data_o <= pend ? pend_b : ~rx_data_o;
  end

  // Modem pin levels
  task automatic lines(input logic c, input logic d, input logic n, input logic r);
    cts_o <= c;
    dsr_o <= d;
    dcd_o <= n;
    ri_o <= r;
  endtask

  // One byte per call, back to back; call right after an edge
  task automatic send(input logic [7:0] b, input logic e);
    pend <= 1'b1;
    pend_b <= b;
    pend_eof <= e;
    @(posedge clk_i);
  endtask

  task automatic idle();
    pend <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rshs_cfg.svh"
module tb
  import rshs_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ce = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] s;
  logic [31:0] r;
  logic [7:0] b;
  logic [7:0] exp_q[$];
  logic cts, dsr, dcd, ri, rts, dtr, tx_valid, tx_ready, rx_valid, rx_eof;
  logic [7:0] tx_data;
  logic [7:0] rx_data;
  wire logic [31:0] pins = {30'h0, dtr, rts};
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;

  rshs_top i_rshs_top (
    .ref_clk_i(clk), .reset_i(rst), .clk_en_i(ce), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .cts_i(cts), .dsr_i(dsr), .dcd_i(dcd), .ri_i(ri),
    .rts_o(rts), .dtr_o(dtr), .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready),
    .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_eof_i(rx_eof)
  );
  rshs_partner i_rshs_partner (
    .clk_i(clk), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready), .cts_o(cts),
    .dsr_o(dsr), .dcd_o(dcd), .ri_o(ri), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_eof_o(rx_eof)
  );

  // ----------------------------------------
  // Clock, watchdog and helpers
  // ----------------------------------------
  initial begin
    forever #25 clk = ~clk;
  end

  // Cuts a hung run short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wreg(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rreg(input logic [2:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic err_is(input logic [15:0] e);
    logic [31:0] v;
    rreg(`RSHS_A_STAT, v);
    chk("err", {16'h0, v[31:16]}, {16'h0, e});
  endtask

  task automatic wait_taken(input int n);
    for (int k = 0; k < 200 && i_rshs_partner.taken.size() < n; k++) begin
      @(posedge clk);
    end
  endtask

  function automatic logic [31:0] stat_exp(input logic [15:0] e, input logic [5:0] p);
    return {e, 10'h0, p};
  endfunction

  function automatic logic [31:0] rxd_exp(input logic [7:0] d, input logic e);
    return {22'h0, 1'b1, e, d};
  endfunction

  // Partner may send while the buffer holds fewer than 50 short of 1024
  function automatic logic rts_free(input int n);
    return n < 1024 - 50;
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    r = $urandom(32'h19c2);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk("pins", pins, 32'h0);
    rreg(3'h7, s);
    chk("unmapped", s, 32'h0);
    rreg(`RSHS_A_STAT, s);
    chk("stat", s, 32'h0);
    rreg(`RSHS_A_TIME, s);
    chk("time", s, {8'h0, `RSHS_R_TIME});
    wreg(`RSHS_A_TIME, 32'h00030202);
    // Host output set and status read against random pin levels
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      i_rshs_partner.lines(r[0], r[1], r[2], r[3]);
      wreg(`RSHS_A_SET, {30'h0, r[5:4]});
      repeat (6) @(posedge clk);
      rreg(`RSHS_A_STAT, s);
      chk("stat", s, stat_exp(16'h0, {r[3:0], r[4], r[5]}));
      chk("pins", pins, {30'h0, r[4], r[5]});
    end
    // Automatic mode: entry, host set refused, timed send
    i_rshs_partner.lines(1'b1, 1'b1, 1'b0, 1'b0);
    wreg(`RSHS_A_CTRL, {30'h0, M_AUTO});
    repeat (3) @(posedge clk);
    #1 chk("pins", pins, 32'h2);
    wreg(`RSHS_A_SET, 32'h2);
    repeat (3) @(posedge clk);
    #1 chk("pins", pins, 32'h2);
    b = 8'($urandom);
    wreg(`RSHS_A_TXD, {24'h1, b});
    repeat (3) @(posedge clk);
    #1 chk("pins", pins, 32'h3);
    chk("early", 32'(i_rshs_partner.taken.size()), 32'h0);
    wait_taken(1);
    chk("tx", {24'h0, i_rshs_partner.taken[0]}, {24'h0, b});
    repeat (5) @(posedge clk);
    #1 chk("pins", pins, 32'h3);
    // Clock enable low freezes the pending release
    ce <= 1'b0;
    repeat (60) @(posedge clk);
    #1 chk("pins", pins, 32'h3);
    ce <= 1'b1;
    repeat (60) @(posedge clk);
    #1 chk("pins", pins, 32'h2);
    // Clear-to-send missing, then lost mid-transfer
    i_rshs_partner.lines(1'b0, 1'b1, 1'b0, 1'b0);
    repeat (6) @(posedge clk);
    wreg(`RSHS_A_TXD, {24'h1, b});
    repeat (80) @(posedge clk);
    err_is(`RSHS_E_CTS);
    i_rshs_partner.stall <= 1'b1;
    i_rshs_partner.lines(1'b1, 1'b1, 1'b0, 1'b0);
    wreg(`RSHS_A_TXD, {24'h0, b});
    repeat (60) @(posedge clk);
    i_rshs_partner.lines(1'b0, 1'b1, 1'b0, 1'b0);
    repeat (10) @(posedge clk);
    err_is(`RSHS_E_CTS);
    i_rshs_partner.stall <= 1'b0;
    // Partner-ready fall during a pending send
    wreg(`RSHS_A_TXD, {24'h1, b});
    repeat (4) @(posedge clk);
    i_rshs_partner.lines(1'b0, 1'b0, 1'b0, 1'b0);
    repeat (10) @(posedge clk);
    err_is(`RSHS_E_DSR);
    rreg(`RSHS_A_DIAG, s);
    chk("diag", {24'h0, s[7:0]}, {24'h0, `RSHS_D_DSR});
    i_rshs_partner.send(b, 1'b1);
    i_rshs_partner.idle();
    repeat (3) @(posedge clk);
    rreg(`RSHS_A_RXD, s);
    chk("rx_valid", {31'h0, s[9]}, 32'h0);
    // Receive a frame with partner ready; oldest byte first
    i_rshs_partner.lines(1'b0, 1'b1, 1'b0, 1'b0);
    repeat (6) @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      exp_q.push_back(8'($urandom));
      i_rshs_partner.send(exp_q[i], i == 2);
    end
    i_rshs_partner.idle();
    repeat (3) @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      rreg(`RSHS_A_RXD, s);
      chk("rxd", s, rxd_exp(exp_q[i], i == 2));
    end
    // Hardware flow control with a frame limit of one
    i_rshs_partner.lines(1'b1, 1'b1, 1'b0, 1'b0);
    wreg(`RSHS_A_CTRL, {22'h0, 8'h01, M_HW});
    repeat (6) @(posedge clk);
    #1 chk("rts", {31'h0, rts}, 32'h1);
    wreg(`RSHS_A_SET, 32'h0);
    repeat (3) @(posedge clk);
    #1 chk("rts", {31'h0, rts}, 32'h1);
    i_rshs_partner.send(b, 1'b1);
    i_rshs_partner.idle();
    repeat (4) @(posedge clk);
    #1 chk("rts", {31'h0, rts}, 32'h0);
    rreg(`RSHS_A_RXD, s);
    chk("rxd", s, rxd_exp(b, 1'b1));
    repeat (3) @(posedge clk);
    #1 chk("rts", {31'h0, rts}, 32'h1);
    // Suspend on clear-to-send loss, then time out
    i_rshs_partner.taken.delete();
    i_rshs_partner.stall <= 1'b1;
    wreg(`RSHS_A_TXD, {24'h0, b});
    // Hold must empty before the next byte is accepted
    repeat (2) @(posedge clk);
    wreg(`RSHS_A_TXD, {24'h1, ~b});
    i_rshs_partner.lines(1'b0, 1'b1, 1'b0, 1'b0);
    repeat (6) @(posedge clk);
    i_rshs_partner.stall <= 1'b0;
    repeat (25) @(posedge clk);
    chk("taken", 32'(i_rshs_partner.taken.size()), 32'h1);
    repeat (100) @(posedge clk);
    err_is(`RSHS_E_FLOW);
    // Software flow control: entry, pause and resume
    i_rshs_partner.taken.delete();
    wreg(`RSHS_A_CTRL, {30'h0, M_SW});
    wait_taken(1);
    chk("xon", {24'h0, i_rshs_partner.taken[0]}, {24'h0, `RSHS_XON});
    i_rshs_partner.send(`RSHS_XOFF, 1'b0);
    i_rshs_partner.idle();
    repeat (4) @(posedge clk);
    wreg(`RSHS_A_TXD, {24'h1, b});
    repeat (20) @(posedge clk);
    chk("taken", 32'(i_rshs_partner.taken.size()), 32'h1);
    i_rshs_partner.send(`RSHS_XON, 1'b0);
    i_rshs_partner.idle();
    wait_taken(2);
    chk("tx", {24'h0, i_rshs_partner.taken[1]}, {24'h0, b});
    // Near-full throttle boundary, then overflow of an endless frame
    wreg(`RSHS_A_CTRL, {30'h0, M_HW});
    for (int n = 1; n <= 1030; n++) begin
      i_rshs_partner.send(8'(n), 1'b0);
      if (n == 973 || n == 974) begin
        i_rshs_partner.idle();
        repeat (3) @(posedge clk);
        #1 chk("rts", {31'h0, rts}, {31'h0, rts_free(n)});
      end
    end
    i_rshs_partner.idle();
    repeat (3) @(posedge clk);
    err_is(`RSHS_E_OVF);
    rreg(`RSHS_A_RXD, s);
    chk("rx_valid", {31'h0, s[9]}, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
